// ### edrg_regs.sv
// Edge de-interlacing and line geometry write-only register bank
//
// How it works
// - Edge match bits 1:0 pick region comparison weight 1, 1/2, 1/4 or 1/8.
// - Edge match bits 3:2 pick region-plus-distance weight 1, 1/2, 1/4, 1/8.
// - Edge match bits 7:4 give minimum luma step, 0 to 60 by 4.
// - Threshold bits 3:0 give minimum edge filter output, 0 to 60 by 4.
// - Threshold bits 5:4 give minimum run length 2, 3, 4 or 5.
// - Compensation bits 3:0 give offset 1 to 16; smaller compensates more.
// - Compensation bits 7:4 limit compensation factor on a 1 to 16 scale.
// - Line total is 10 bits: block register bits 7:6 over next register.
// - Fetch strobe shifts by 0, +1, +2, +3, -4, -3, -2, -1 pixels.
`timescale 1ns/1ps
module edrg_regs (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_wr_en,
	input wire logic [7:0] i_wr_addr,
	input wire logic [7:0] i_wr_data,
	input wire logic i_fetch_strobe_ref,
	output logic [1:0] o_edge_region_match_factor,
	output logic [1:0] o_edge_distance_match_factor,
	output logic [5:0] o_edge_luma_step_min,
	output logic [5:0] o_edge_filter_min,
	output logic [2:0] o_edge_run_length_min,
	output logic [4:0] o_edge_comp_offset,
	output logic [4:0] o_edge_comp_limit,
	output logic [5:0] o_active_block_count,
	output logic [9:0] o_output_line_total,
	output logic [7:0] o_line_pixel_total_eighths,
	output logic [2:0] o_output_fetch_strobe_shift,
	output logic o_output_fetch_strobe
);
	logic [7:0] edge_match_q;
	logic [7:0] edge_thresh_q;
	logic [7:0] edge_comp_q;
	logic [7:0] block_line_q;
	logic [7:0] line_low_q;
	logic [7:0] line_len_q;
	logic [7:0] strobe_shift_q;
	logic [7:0] spare_shift_q;
	logic [3:0] luma_nib;
	logic [3:0] filt_nib;
	logic [1:0] run_code;
	logic [3:0] ofs_nib;
	logic [3:0] lim_nib;

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			edge_match_q <= edrg_pkg::RESET_VALUE;
			edge_thresh_q <= edrg_pkg::RESET_VALUE;
			edge_comp_q <= edrg_pkg::RESET_VALUE;
		end else if (i_wr_en) begin
			unique case (i_wr_addr)
				edrg_pkg::ADDR_EDGE_MATCH: begin
					edge_match_q <= i_wr_data;
				end
				edrg_pkg::ADDR_EDGE_THRESH: begin
					edge_thresh_q <= i_wr_data;
				end
				edrg_pkg::ADDR_EDGE_COMP: begin
					edge_comp_q <= i_wr_data;
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			block_line_q <= edrg_pkg::RESET_VALUE;
			line_low_q <= edrg_pkg::RESET_VALUE;
			line_len_q <= edrg_pkg::RESET_VALUE;
			strobe_shift_q <= edrg_pkg::RESET_VALUE;
			spare_shift_q <= edrg_pkg::RESET_VALUE;
		end else if (i_wr_en) begin
			unique case (i_wr_addr)
				edrg_pkg::ADDR_ACTIVE_BLOCK: begin
					block_line_q <= i_wr_data;
				end
				edrg_pkg::ADDR_LINE_LOW: begin
					line_low_q <= i_wr_data;
				end
				edrg_pkg::ADDR_LINE_LENGTH: begin
					line_len_q <= i_wr_data;
				end
				edrg_pkg::ADDR_STROBE_SHIFT: begin
					strobe_shift_q <= i_wr_data;
				end
				edrg_pkg::ADDR_SPARE_SHIFT: begin
					spare_shift_q <= i_wr_data; // Reserved, kept but drives nothing
				end
				default: begin
				end
			endcase
		end
	end

	// Field extraction; unassigned bits are simply never read
	assign luma_nib = edge_match_q[edrg_pkg::LUMA_STEP_LSB +: edrg_pkg::NIBBLE_W];
	assign filt_nib = edge_thresh_q[edrg_pkg::FILTER_MIN_LSB +: edrg_pkg::NIBBLE_W];
	assign run_code = edge_thresh_q[edrg_pkg::RUN_LEN_LSB +: edrg_pkg::RUN_LEN_W];
	assign ofs_nib = edge_comp_q[edrg_pkg::COMP_OFFSET_LSB +: edrg_pkg::NIBBLE_W];
	assign lim_nib = edge_comp_q[edrg_pkg::COMP_LIMIT_LSB +: edrg_pkg::NIBBLE_W];

	assign o_edge_region_match_factor =
		edge_match_q[edrg_pkg::REGION_MATCH_LSB +: edrg_pkg::MATCH_FACTOR_W];
	assign o_edge_distance_match_factor =
		edge_match_q[edrg_pkg::DIST_MATCH_LSB +: edrg_pkg::MATCH_FACTOR_W];
	// luma step in units of four
	assign o_edge_luma_step_min = {luma_nib, 2'b00};
	// filter minimum in units of four
	assign o_edge_filter_min = {filt_nib, 2'b00};
	assign o_edge_run_length_min = 3'({1'b0, run_code} + edrg_pkg::RUN_LEN_BASE);
	assign o_edge_comp_offset = 5'({1'b0, ofs_nib} + edrg_pkg::COMP_BASE);
	assign o_edge_comp_limit = 5'({1'b0, lim_nib} + edrg_pkg::COMP_BASE);

	// block count passed on as written; range is the host's duty
	assign o_active_block_count =
		block_line_q[edrg_pkg::BLOCK_COUNT_LSB +: edrg_pkg::BLOCK_COUNT_W];
	// ten-bit line total across two registers
	assign o_output_line_total =
		{block_line_q[edrg_pkg::LINE_HIGH_LSB +: edrg_pkg::LINE_HIGH_W], line_low_q};
	// line length used without range clamping
	assign o_line_pixel_total_eighths = line_len_q;
	assign o_output_fetch_strobe_shift =
		strobe_shift_q[edrg_pkg::STROBE_SHIFT_LSB +: edrg_pkg::STROBE_SHIFT_W];

	edrg_strobe_shift u_strobe (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_strobe(i_fetch_strobe_ref),
		.i_shift(o_output_fetch_strobe_shift),
		.o_strobe(o_output_fetch_strobe)
	);

	AST_REGION_FACTOR: assert property (@(posedge i_clk) disable iff (i_rst)
		i_wr_en && i_wr_addr == edrg_pkg::ADDR_EDGE_MATCH
		|=> o_edge_region_match_factor == $past(i_wr_data[1:0]))
		else $error("region factor not taken from bits 1:0");

	AST_DIST_FACTOR: assert property (@(posedge i_clk) disable iff (i_rst)
		i_wr_en && i_wr_addr == edrg_pkg::ADDR_EDGE_MATCH
		|=> o_edge_distance_match_factor == $past(i_wr_data[3:2]))
		else $error("distance factor not taken from bits 3:2");

	AST_LUMA_STEP: assert property (@(posedge i_clk) disable iff (i_rst)
		i_wr_en && i_wr_addr == edrg_pkg::ADDR_EDGE_MATCH && i_wr_data[7:4] == 4'hf
		|=> o_edge_luma_step_min == 6'h3c)
		else $error("luma step top code not 60");

	AST_FILTER_MIN: assert property (@(posedge i_clk) disable iff (i_rst)
		i_wr_en && i_wr_addr == edrg_pkg::ADDR_EDGE_THRESH
		|=> o_edge_filter_min == {$past(i_wr_data[3:0]), 2'b00})
		else $error("filter minimum wrong");

	AST_RUN_LENGTH: assert property (@(posedge i_clk) disable iff (i_rst)
		i_wr_en && i_wr_addr == edrg_pkg::ADDR_EDGE_THRESH
		|=> o_edge_run_length_min == 3'({1'b0, $past(i_wr_data[5:4])} + 3'h2))
		else $error("run length not code plus two");

	AST_COMP_OFFSET: assert property (@(posedge i_clk) disable iff (i_rst)
		i_wr_en && i_wr_addr == edrg_pkg::ADDR_EDGE_COMP
		|=> o_edge_comp_offset == {1'b0, $past(i_wr_data[3:0])} + 5'h01)
		else $error("compensation offset wrong");

	AST_COMP_LIMIT: assert property (@(posedge i_clk) disable iff (i_rst)
		i_wr_en && i_wr_addr == edrg_pkg::ADDR_EDGE_COMP && i_wr_data[7:4] == 4'hf
		|=> o_edge_comp_limit == 5'h10)
		else $error("compensation limit top code not 16");

	AST_LINE_TOTAL: assert property (@(posedge i_clk) disable iff (i_rst)
		i_wr_en && i_wr_addr == edrg_pkg::ADDR_ACTIVE_BLOCK
		|=> o_output_line_total[9:8] == $past(i_wr_data[7:6])
			&& o_active_block_count == $past(i_wr_data[5:0]))
		else $error("line total high bits or block count wrong");

	AST_HOLD_VALUE: assert property (@(posedge i_clk) disable iff (i_rst)
		!i_wr_en |=> $stable(o_output_line_total) && $stable(o_edge_comp_limit)
			&& $stable(o_line_pixel_total_eighths))
		else $error("register changed without a write");

	AST_SPARE_NO_EFFECT: assert property (@(posedge i_clk) disable iff (i_rst)
		i_wr_en && i_wr_addr == edrg_pkg::ADDR_SPARE_SHIFT
		|=> $stable(o_output_fetch_strobe_shift) && $stable(o_edge_filter_min))
		else $error("reserved register altered behaviour");

	// Whole-range checks; the top-code checks above miss a broken low code
	AST_LUMA_STEP_ALL: assert property (@(posedge i_clk) disable iff (i_rst)
		i_wr_en && i_wr_addr == edrg_pkg::ADDR_EDGE_MATCH
		|=> o_edge_luma_step_min == {$past(i_wr_data[7:4]), 2'b00})
		else $error("luma step not four times the code");

	AST_COMP_LIMIT_ALL: assert property (@(posedge i_clk) disable iff (i_rst)
		i_wr_en && i_wr_addr == edrg_pkg::ADDR_EDGE_COMP
		|=> o_edge_comp_limit == 5'({1'b0, $past(i_wr_data[7:4])} + 5'h01))
		else $error("compensation limit not code plus one");

	AST_LINE_LOW: assert property (@(posedge i_clk) disable iff (i_rst)
		i_wr_en && i_wr_addr == edrg_pkg::ADDR_LINE_LOW
		|=> o_output_line_total[7:0] == $past(i_wr_data))
		else $error("line total low byte wrong");

	AST_LINE_LENGTH: assert property (@(posedge i_clk) disable iff (i_rst)
		i_wr_en && i_wr_addr == edrg_pkg::ADDR_LINE_LENGTH
		|=> o_line_pixel_total_eighths == $past(i_wr_data))
		else $error("line length not the written byte");

	AST_SHIFT_CODE: assert property (@(posedge i_clk) disable iff (i_rst)
		i_wr_en && i_wr_addr == edrg_pkg::ADDR_STROBE_SHIFT
		|=> o_output_fetch_strobe_shift == $past(i_wr_data[2:0]))
		else $error("strobe shift code not taken from bits 2:0");

	AST_STROBE_NO_LAG: assert property (@(posedge i_clk) disable iff (i_rst)
		o_output_fetch_strobe_shift == 3'h4 |-> o_output_fetch_strobe == i_fetch_strobe_ref)
		else $error("minus four shift does not pass the strobe straight");
endmodule // edrg_regs

// ### edrg_pkg.sv
// Package of offsets, field layouts and reset values for the edge/geometry register bank
package edrg_pkg;
	// Register addresses on the serial control interface
	localparam logic [7:0] ADDR_ACTIVE_BLOCK = 8'h20;
	localparam logic [7:0] ADDR_LINE_LOW = 8'h21;
	localparam logic [7:0] ADDR_LINE_LENGTH = 8'h22;
	localparam logic [7:0] ADDR_STROBE_SHIFT = 8'h23;
	localparam logic [7:0] ADDR_SPARE_SHIFT = 8'h24;
	localparam logic [7:0] ADDR_EDGE_MATCH = 8'hf1;
	localparam logic [7:0] ADDR_EDGE_THRESH = 8'hf2;
	localparam logic [7:0] ADDR_EDGE_COMP = 8'hf3;

	// Field positions (low bit) and widths
	localparam int REGION_MATCH_LSB = 0;
	localparam int DIST_MATCH_LSB = 2;
	localparam int MATCH_FACTOR_W = 2;
	localparam int LUMA_STEP_LSB = 4;
	localparam int FILTER_MIN_LSB = 0;
	localparam int NIBBLE_W = 4;
	localparam int RUN_LEN_LSB = 4;
	localparam int RUN_LEN_W = 2;
	localparam int COMP_OFFSET_LSB = 0;
	localparam int COMP_LIMIT_LSB = 4;
	localparam int BLOCK_COUNT_LSB = 0;
	localparam int BLOCK_COUNT_W = 6;
	localparam int LINE_HIGH_LSB = 6;
	localparam int LINE_HIGH_W = 2;
	localparam int LINE_TOTAL_W = 10;
	localparam int STROBE_SHIFT_LSB = 0;
	localparam int STROBE_SHIFT_W = 3;
	localparam int SPARE_SHIFT_LSB = 0;

	// Scaling of decoded values
	localparam int STEP_SCALE_SHIFT = 2;
	localparam logic [2:0] RUN_LEN_BASE = 3'h2;
	localparam logic [4:0] COMP_BASE = 5'h01;
	localparam logic [2:0] STROBE_NOMINAL_DELAY = 3'h4;

	// Reset contents of every register
	localparam logic [7:0] RESET_VALUE = 8'h00;
endpackage

// ### edrg_strobe_shift.sv
// Output fetch strobe shifter with a signed pixel offset
`timescale 1ns/1ps
module edrg_strobe_shift (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_strobe,
	input wire logic [2:0] i_shift,
	output logic o_strobe
);
	logic [7:0] taps;
	logic [6:0] dly_q;
	logic [2:0] sel;

	// Delay line; tap n is the reference strobe n pixels late
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			dly_q <= 7'h00;
		end else begin
			dly_q <= {dly_q[5:0], i_strobe};
		end
	end

	// Negative shifts cannot look ahead, so the whole range rides on a nominal lag
	assign taps = {dly_q, i_strobe};
	assign sel = 3'(i_shift + edrg_pkg::STROBE_NOMINAL_DELAY);
	assign o_strobe = taps[sel];

	// Shift code 0 means exactly the nominal lag
	AST_STROBE_NOMINAL: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_shift == 3'h0) && $stable(i_shift) ##0 $past(i_strobe, 4) |-> o_strobe == 1'b1)
		else $error("strobe at nominal lag missing");
endmodule // edrg_strobe_shift

// ### edrg_host_model.sv
// Host controller model that puts byte writes onto the register write port
`timescale 1ns/1ps
module edrg_host_model (
	input wire logic i_req,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_data,
	output logic o_wr_en,
	output logic [7:0] o_wr_addr,
	output logic [7:0] o_wr_data
);
	logic [7:0] last_addr = 8'h00;
	logic [7:0] last_data = 8'h00;
	// Remember the last byte so idle lines can move away from it
	always @(i_req or i_addr or i_data) begin
		if (i_req) begin
			last_addr = i_addr;
			last_data = i_data;
		end
	end
	// Idle lines show the inverse, so a stale byte never passes for a fresh one
	assign o_wr_en = i_req;
	assign o_wr_addr = i_req ? i_addr : ~last_addr;
	assign o_wr_data = i_req ? i_data : ~last_data;
endmodule // edrg_host_model

// ### testbench.sv
// Self-checking bench for the edge and line geometry register bank
`timescale 1ns/1ps
module testbench;
	logic i_clk = 1'b0;
	logic i_rst = 1'b1;
	logic req = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] data = 8'h00;
	logic ref_strobe = 1'b0;
	logic wr_en;
	logic [7:0] wr_addr, wr_data;
	logic [1:0] rmf, dmf;
	logic [5:0] luma, filt, blks;
	logic [2:0] run, shft;
	logic [4:0] ofs, lim;
	logic [9:0] lines;
	logic [7:0] len;
	logic strobe;
	int fail_count = 0;
	int samples_checked = 0;
	int got;
	logic [4:0] i;
	logic [3:0] dly [8] = '{4'h4, 4'h5, 4'h6, 4'h7, 4'h0, 4'h1, 4'h2, 4'h3};

	edrg_host_model u_edrg_host_model (.i_req(req), .i_addr(addr), .i_data(data),
		.o_wr_en(wr_en), .o_wr_addr(wr_addr), .o_wr_data(wr_data));
	edrg_regs u_edrg_regs (.i_clk(i_clk), .i_rst(i_rst), .i_wr_en(wr_en), .i_wr_addr(wr_addr),
		.i_wr_data(wr_data), .i_fetch_strobe_ref(ref_strobe),
		.o_edge_region_match_factor(rmf), .o_edge_distance_match_factor(dmf),
		.o_edge_luma_step_min(luma), .o_edge_filter_min(filt), .o_edge_run_length_min(run),
		.o_edge_comp_offset(ofs), .o_edge_comp_limit(lim), .o_active_block_count(blks),
		.o_output_line_total(lines), .o_line_pixel_total_eighths(len),
		.o_output_fetch_strobe_shift(shft), .o_output_fetch_strobe(strobe));

	// Free-running 25 MHz pixel clock
	initial begin
		forever #20 i_clk = ~i_clk;
	end

	// One comparison, counted; a difference is reported at once
	task automatic check_val(input logic [9:0] seen, input logic [9:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Raise a write; consecutive calls give back-to-back bytes
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk);
		req <= 1'b1;
		addr <= a;
		data <= d;
	endtask

	// Drop the strobe and let the last byte land
	task automatic idle();
		@(posedge i_clk);
		req <= 1'b0;
		#1;
	endtask

	task automatic tally_and_finish();
		$display("Comparisons %0d, mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	initial begin
		repeat (5) @(posedge i_clk);
		i_rst <= 1'b0;
		#1;
		// Designer-chosen reset contents decode to base values
		check_val(10'(run), 10'h002);
		check_val(10'({ofs, lim}), 10'h021);
		check_val(10'({rmf, dmf, luma}), 10'h000);
		check_val(10'(blks), 10'h000);
		check_val(lines, 10'h000);
		check_val(10'({filt, shft}), 10'h000);
		check_val(10'(len), 10'h000);
		// Every code of the three edge registers; unassigned bits set high
		for (i = 5'h00; i < 5'h10; i++) begin
			wr(edrg_pkg::ADDR_EDGE_MATCH, {i[3:0], i[1:0], ~i[1:0]});
			wr(edrg_pkg::ADDR_EDGE_THRESH, {2'b11, i[1:0], i[3:0]});
			wr(edrg_pkg::ADDR_EDGE_COMP, {i[3:0], ~i[3:0]});
			idle();
			check_val(10'(rmf), {8'h00, ~i[1:0]});
			check_val(10'(dmf), 10'(i[1:0]));
			check_val(10'(luma), 10'({i[3:0], 2'b00}));
			check_val(10'(filt), 10'({i[3:0], 2'b00}));
			check_val(10'(run), 10'(i[1:0]) + 10'h002);
			check_val(10'(ofs), 10'h010 - 10'(i[3:0]));
			check_val(10'(lim), 10'(i[3:0]) + 10'h001);
		end
		// Host keeps 53 blocks, 128 eighths: blanking 22 lies in range
		wr(edrg_pkg::ADDR_ACTIVE_BLOCK, 8'hb5);
		wr(edrg_pkg::ADDR_LINE_LOW, 8'h5a);
		wr(edrg_pkg::ADDR_LINE_LENGTH, 8'h80);
		idle();
		check_val(10'(blks), 10'h035);
		check_val(lines, 10'h25a);
		check_val(10'(len), 10'h080);
		// Low byte alone leaves the high bits; smallest legal geometry next
		wr(edrg_pkg::ADDR_LINE_LOW, 8'h01);
		idle();
		check_val(lines, 10'h201);
		wr(edrg_pkg::ADDR_ACTIVE_BLOCK, 8'h46);
		wr(edrg_pkg::ADDR_LINE_LENGTH, 8'h50);
		// Unmapped and reserved places must leave everything alone
		wr(8'h1f, 8'hff);
		wr(8'h25, 8'hff);
		wr(edrg_pkg::ADDR_SPARE_SHIFT, 8'hff);
		wr(8'hf0, 8'hff);
		wr(8'hf4, 8'hff);
		idle();
		check_val({blks, 4'h0}, 10'h060);
		check_val(lines, 10'h101);
		check_val(10'(len), 10'h050);
		check_val(10'({ofs, lim}), 10'h030);
		check_val(10'(shft), 10'h000);
		// Each strobe shift code against its pixel delay
		for (i = 5'h00; i < 5'h08; i++) begin
			wr(edrg_pkg::ADDR_STROBE_SHIFT, {5'h1f, i[2:0]});
			idle();
			check_val(10'(shft), 10'(i[2:0]));
			repeat (10) @(posedge i_clk);
			ref_strobe <= 1'b1;
			got = 99;
			for (int k = 0; k < 11; k++) begin
				#1;
				if (strobe === 1'b1 && got == 99) got = k;
				@(posedge i_clk);
				ref_strobe <= 1'b0;
			end
			check_val(10'(got), 10'(dly[i[2:0]]));
		end
		tally_and_finish();
	end
endmodule // testbench
